// [fas_pkg.sv]
// Constants, operation codes and state layout of the fractional shifter.
// Assumes nothing of its surroundings; shared by every design file.
package fas_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned LONG_W     = 32;
  localparam int unsigned COUNT_W    = 16;
  localparam int unsigned AMT_W      = 6;
  localparam int unsigned LOW_CNT_W  = 5;

  // ----------------------------------------------------------------------
  // Counts and limits
  // ----------------------------------------------------------------------
  localparam logic [5:0]  NOCLAMP_LIMIT_16 = 6'h0f;
  localparam logic [5:0]  NOCLAMP_LIMIT_32 = 6'h1f;
  localparam logic [5:0]  AMT_CAP          = 6'h3f;
  localparam logic [5:0]  NEG_LOW_BASE     = 6'h20;
  localparam int unsigned LATENCY_CYCLES   = 1;

  // ----------------------------------------------------------------------
  // Values after reset and fill values
  // ----------------------------------------------------------------------
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [15:0] LOW_PORTION_CLEAR = 16'h0000;
  localparam logic [15:0] WORD_ZERO    = 16'h0000;
  localparam logic [31:0] LONG_ZERO    = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_BIDIR_LEFT_CLAMP_16,
    OP_BIDIR_LEFT_NOCLAMP_16,
    OP_LEFT_ONLY_CLAMP_16,
    OP_BIDIR_RIGHT_CLAMP_16,
    OP_BIDIR_RIGHT_ROUND_16,
    OP_BIDIR_RIGHT_NOCLAMP_16,
    OP_BIDIR_LEFT_CLAMP_32,
    OP_BIDIR_LEFT_NOCLAMP_32,
    OP_LEFT_ONLY_CLAMP_32,
    OP_BIDIR_RIGHT_CLAMP_32,
    OP_BIDIR_RIGHT_ROUND_32,
    OP_BIDIR_RIGHT_NOCLAMP_32
  } fas_op_e;

  // ----------------------------------------------------------------------
  // Registered state of the top module
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] result;
    logic        valid;
    logic        clamped;
  } fas_state_s;

endpackage

// [fas_clamp_shl.sv]
// Arithmetic left shift of a W-bit value with optional clamping.
// Assumes a settled operand and amount from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module fas_clamp_shl #(
  parameter int unsigned W = 16
) (
  // Operand
  input  wire logic [W-1:0]            value_i,
  input  wire logic [fas_pkg::AMT_W-1:0] amount_i,
  input  wire logic                    clamp_en_i,
  // Result
  output logic      [W-1:0]            result_o,
  output logic                         clamped_o
);

  // ----------------------------------------------------------------------
  // Shift and overflow test
  // ----------------------------------------------------------------------
  logic [W-1:0] shifted;
  logic [W-1:0] back;
  logic         overflow;

  always_comb begin
    shifted  = value_i << amount_i;
    back     = W'($signed(shifted) >>> amount_i);
    overflow = (back != value_i);
    if (clamp_en_i && overflow) begin
      // Clamp towards the sign of the true result
      result_o  = value_i[W-1] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
      clamped_o = 1'b1;
    end else begin
      result_o  = shifted;
      clamped_o = 1'b0;
    end
  end

endmodule
`default_nettype wire

// [fas_round_shr.sv]
// Arithmetic right shift of a W-bit value with optional rounding.
// Assumes a settled operand and amount from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module fas_round_shr #(
  parameter int unsigned W = 16
) (
  // Operand
  input  wire logic [W-1:0]              value_i,
  input  wire logic [fas_pkg::AMT_W-1:0] amount_i,
  input  wire logic                      round_en_i,
  input  wire logic                      twos_i,
  // Result
  output logic      [W-1:0]              result_o,
  output logic                           rounded_o
);

  // ----------------------------------------------------------------------
  // Shift, remainder and rounding decision
  // ----------------------------------------------------------------------
  logic [W-1:0] shifted;
  logic [W-1:0] mask;
  logic [W-1:0] half;
  logic [W-1:0] rem;
  logic         bump;

  always_comb begin
    shifted = W'($signed(value_i) >>> amount_i);
    mask    = ~({W{1'b1}} << amount_i);
    half    = {{(W-1){1'b0}}, 1'b1} << (amount_i - 1'b1);
    rem     = value_i & mask;
    bump    = 1'b0;
    if (round_en_i && (amount_i != '0) && (amount_i < W)) begin
      if (twos_i) begin
        bump = (rem >= half);
      end else begin
        bump = (rem > half) || ((rem == half) && shifted[0]);
      end
    end
    result_o  = shifted + {{(W-1){1'b0}}, bump};
    rounded_o = bump;
  end

endmodule
`default_nettype wire

// [fas_shifter.sv]
// Fractional arithmetic shifter of a fixed-point data ALU, one-cycle latency.
// Assumes operands, count and operation come from decode on clk_i.
//
// Function
// - Saturating left-biased 16: left if positive, clamp
// - Non-clamping left-biased 16: never clamps left results
// - Non-clamping counts use sign and low five bits
// - Left-biased 16, positive count above fifteen: zero
// - Left-biased 16, negative beyond fifteen: sign fill
// - Right-biased 16, positive above fifteen: sign fill
// - Right-biased 16, negative beyond fifteen: zero
// - Right-biased: right if positive, else left
// - Rounding 16: round right shifts, clamp left
// - Left-only 16: left shift, clamp on overflow
// - Accumulator target clears low portion for listed variants
// - 32-bit bidirectional, non-clamping and rounding variants
// - Left-only 32: left shift, clamp 32-bit result
// - Rounding 32: round right shifts, clamp left
// - Rounding bit picks two's complement over convergent
`timescale 1ns/1ns
`default_nettype none
module fas_shifter (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          reset_i,
  // Request
  input  wire logic                          valid_i,
  input  wire fas_pkg::fas_op_e              op_i,
  input  wire logic [fas_pkg::LONG_W-1:0]    shift_operand_i,
  input  wire logic [fas_pkg::COUNT_W-1:0]   count_i,
  input  wire logic                          to_accum_i,
  // Mode bits
  input  wire logic                          clamp_enable_bit_i,
  input  wire logic                          round_twos_i,
  // Result
  output logic      [fas_pkg::LONG_W-1:0]    result_o,
  output logic                               valid_o,
  output logic                               clamped_o
);

  // ----------------------------------------------------------------------
  // Operation decoding
  // ----------------------------------------------------------------------
  function automatic logic op_is_long(input fas_pkg::fas_op_e op);
    case (op)
      fas_pkg::OP_BIDIR_LEFT_CLAMP_32,
      fas_pkg::OP_BIDIR_LEFT_NOCLAMP_32,
      fas_pkg::OP_LEFT_ONLY_CLAMP_32,
      fas_pkg::OP_BIDIR_RIGHT_CLAMP_32,
      fas_pkg::OP_BIDIR_RIGHT_ROUND_32,
      fas_pkg::OP_BIDIR_RIGHT_NOCLAMP_32: op_is_long = 1'b1;
      default: op_is_long = 1'b0;
    endcase
  endfunction

  function automatic logic op_left_biased(input fas_pkg::fas_op_e op);
    case (op)
      fas_pkg::OP_BIDIR_LEFT_CLAMP_16,
      fas_pkg::OP_BIDIR_LEFT_NOCLAMP_16,
      fas_pkg::OP_BIDIR_LEFT_CLAMP_32,
      fas_pkg::OP_BIDIR_LEFT_NOCLAMP_32: op_left_biased = 1'b1;
      default: op_left_biased = 1'b0;
    endcase
  endfunction

  function automatic logic op_left_only(input fas_pkg::fas_op_e op);
    case (op)
      fas_pkg::OP_LEFT_ONLY_CLAMP_16,
      fas_pkg::OP_LEFT_ONLY_CLAMP_32: op_left_only = 1'b1;
      default: op_left_only = 1'b0;
    endcase
  endfunction

  function automatic logic op_noclamp(input fas_pkg::fas_op_e op);
    case (op)
      fas_pkg::OP_BIDIR_LEFT_NOCLAMP_16,
      fas_pkg::OP_BIDIR_RIGHT_NOCLAMP_16,
      fas_pkg::OP_BIDIR_LEFT_NOCLAMP_32,
      fas_pkg::OP_BIDIR_RIGHT_NOCLAMP_32: op_noclamp = 1'b1;
      default: op_noclamp = 1'b0;
    endcase
  endfunction

  function automatic logic op_rounds(input fas_pkg::fas_op_e op);
    case (op)
      fas_pkg::OP_BIDIR_RIGHT_ROUND_16,
      fas_pkg::OP_BIDIR_RIGHT_ROUND_32: op_rounds = 1'b1;
      default: op_rounds = 1'b0;
    endcase
  endfunction

  // Variants whose accumulator destination gets a cleared low portion
  function automatic logic op_clears_low(input fas_pkg::fas_op_e op);
    case (op)
      fas_pkg::OP_BIDIR_LEFT_CLAMP_16,
      fas_pkg::OP_BIDIR_LEFT_NOCLAMP_16,
      fas_pkg::OP_LEFT_ONLY_CLAMP_16,
      fas_pkg::OP_BIDIR_RIGHT_CLAMP_16,
      fas_pkg::OP_BIDIR_RIGHT_ROUND_16,
      fas_pkg::OP_BIDIR_RIGHT_NOCLAMP_16,
      fas_pkg::OP_BIDIR_LEFT_CLAMP_32,
      fas_pkg::OP_BIDIR_RIGHT_CLAMP_32: op_clears_low = 1'b1;
      default: op_clears_low = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Count decoding
  // ----------------------------------------------------------------------
  logic                        cnt_neg;
  logic [fas_pkg::COUNT_W-1:0] cnt_abs;
  logic [fas_pkg::AMT_W-1:0]   full_amt;
  logic [fas_pkg::LOW_CNT_W-1:0] low_cnt;
  logic                        low_pos;
  logic [fas_pkg::AMT_W-1:0]   low_amt;
  logic                        go_left;
  logic [fas_pkg::AMT_W-1:0]   amt;

  always_comb begin
    cnt_neg = count_i[fas_pkg::COUNT_W-1];
    cnt_abs = cnt_neg ? (~count_i + 1'b1) : count_i;
    if (cnt_abs > fas_pkg::COUNT_W'(fas_pkg::AMT_CAP)) begin
      full_amt = fas_pkg::AMT_CAP;
    end else begin
      full_amt = cnt_abs[fas_pkg::AMT_W-1:0];
    end
    // Only the sign and the low five bits count
    low_cnt = count_i[fas_pkg::LOW_CNT_W-1:0];
    low_pos = !cnt_neg && (low_cnt != '0);
    low_amt = cnt_neg ? (fas_pkg::NEG_LOW_BASE - {1'b0, low_cnt}) : {1'b0, low_cnt};
    if (op_left_only(op_i)) begin
      // Count taken as positive
      go_left = 1'b1;
      amt     = full_amt;
    end else if (op_noclamp(op_i)) begin
      // Sign and low five bits pick the direction
      if (op_left_biased(op_i)) begin
        go_left = low_pos;
      end else begin
        go_left = !low_pos;
      end
      amt = low_amt;
    end else begin
      // Positive count means greater than zero
      if (op_left_biased(op_i)) begin
        go_left = !cnt_neg && (count_i != '0);
      end else begin
        go_left = cnt_neg || (count_i == '0);
      end
      amt = full_amt;
    end
  end

  // ----------------------------------------------------------------------
  // Clamping left shifters and rounding right shifters
  // ----------------------------------------------------------------------
  logic        clamp_en;
  logic        round_en;
  logic [15:0] shl16;
  logic [31:0] shl32;
  logic [15:0] shr16;
  logic [31:0] shr32;
  logic        clamped16;
  logic        clamped32;

  // Clamping relies on the mode bit being settled beforehand
  assign clamp_en = clamp_enable_bit_i && !op_noclamp(op_i);
  assign round_en = op_rounds(op_i);

  fas_clamp_shl #(
    .W (fas_pkg::WORD_W)
  ) u_shl16 (
    .value_i    (shift_operand_i[15:0]),
    .amount_i   (amt),
    .clamp_en_i (clamp_en),
    .result_o   (shl16),
    .clamped_o  (clamped16)
  );

  fas_clamp_shl #(
    .W (fas_pkg::LONG_W)
  ) u_shl32 (
    .value_i    (shift_operand_i),
    .amount_i   (amt),
    .clamp_en_i (clamp_en),
    .result_o   (shl32),
    .clamped_o  (clamped32)
  );

  // Rounding style follows the mode bit
  fas_round_shr #(
    .W (fas_pkg::WORD_W)
  ) u_shr16 (
    .value_i    (shift_operand_i[15:0]),
    .amount_i   (amt),
    .round_en_i (round_en),
    .twos_i     (round_twos_i),
    .result_o   (shr16),
    .rounded_o  ()
  );

  fas_round_shr #(
    .W (fas_pkg::LONG_W)
  ) u_shr32 (
    .value_i    (shift_operand_i),
    .amount_i   (amt),
    .round_en_i (round_en),
    .twos_i     (round_twos_i),
    .result_o   (shr32),
    .rounded_o  ()
  );

  // ----------------------------------------------------------------------
  // Result selection
  // ----------------------------------------------------------------------
  logic [15:0] res16;
  logic [31:0] res32;
  logic        res_clamped;
  logic [31:0] res_out;
  logic        sign16;
  logic        sign32;
  logic        clear_low;

  always_comb begin
    clear_low   = to_accum_i && op_clears_low(op_i);
    sign16      = shift_operand_i[15];
    sign32      = shift_operand_i[31];
    res16       = shr16;
    res32       = shr32;
    res_clamped = 1'b0;
    if (op_noclamp(op_i)) begin
      if (go_left) begin
        // Plain left shift, out-of-range count gives zero
        res16 = 16'(shift_operand_i[15:0] << amt);
        res32 = shift_operand_i << amt;
        if (amt > fas_pkg::NOCLAMP_LIMIT_16) begin
          res16 = fas_pkg::WORD_ZERO;
        end
        if (amt > fas_pkg::NOCLAMP_LIMIT_32) begin
          res32 = fas_pkg::LONG_ZERO;
        end
      end else begin
        // Out-of-range right shift fills with the sign
        if (amt > fas_pkg::NOCLAMP_LIMIT_16) begin
          res16 = {16{sign16}};
        end
        if (amt > fas_pkg::NOCLAMP_LIMIT_32) begin
          res32 = {32{sign32}};
        end
      end
    end else if (go_left) begin
      // Clamped left shift
      res16       = shl16;
      res32       = shl32;
      res_clamped = op_is_long(op_i) ? clamped32 : clamped16;
    end else begin
      // Right shift, rounded for the rounding variants
      res16 = shr16;
      res32 = shr32;
    end
    if (op_is_long(op_i)) begin
      res_out = res32;
      if (clear_low) begin
        res_out[15:0] = fas_pkg::LOW_PORTION_CLEAR;
      end
    end else if (clear_low) begin
      res_out = {res16, fas_pkg::LOW_PORTION_CLEAR};
    end else begin
      res_out = {{16{res16[15]}}, res16};
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  fas_pkg::fas_state_s state;
  fas_pkg::fas_state_s next_state;

  always_comb begin
    next_state = state;
    next_state.valid = valid_i;
    if (valid_i) begin
      // Result captured on the next edge
      next_state.result  = res_out;
      next_state.clamped = res_clamped;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= '{result: fas_pkg::RESULT_RESET, valid: 1'b0, clamped: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign result_o  = state.result;
  assign valid_o   = state.valid;
  assign clamped_o = state.clamped;

endmodule
`default_nettype wire

// [fas_decode_model.sv]
// Decode-side model that issues shift requests and mode bits.
// Assumes the bench calls its tasks from one process on clk_i.
`timescale 1ns/1ns
`default_nettype none
module fas_decode_model (
  // Clock
  input  wire logic             clk_i,
  // Request
  output var  logic             valid_o,
  output var  fas_pkg::fas_op_e op_o,
  output var  logic [31:0]      operand_o,
  output var  logic [15:0]      count_o,
  output var  logic             to_accum_o,
  // Mode bits
  output var  logic             clamp_en_o,
  output var  logic             twos_o
);
  initial begin
    valid_o = 1'b0;
    op_o = fas_pkg::OP_BIDIR_LEFT_CLAMP_16;
    operand_o = 32'h0000_0000;
    count_o = 16'h0000;
    to_accum_o = 1'b0;
    clamp_en_o = 1'b0;
    twos_o = 1'b1;
  end
  task automatic issue(input fas_pkg::fas_op_e op, input logic [31:0] a,
                       input logic [15:0] c, input logic acc);
    @(posedge clk_i);
    #1;
    valid_o = 1'b1;
    op_o = op;
    operand_o = a;
    count_o = c;
    to_accum_o = acc;
  endtask
  // Operand and count lines toggle when idle so stale values are never mistaken for a request
  task automatic idle();
    @(posedge clk_i);
    #1;
    valid_o = 1'b0;
    operand_o = ~operand_o;
    count_o = ~count_o;
  endtask
  // Mode bits settle three idle cycles before the next request
  task automatic set_mode(input logic s, input logic t);
    idle();
    clamp_en_o = s;
    twos_o = t;
    repeat (3) idle();
  endtask
endmodule
`default_nettype wire

// [fas_shifter_sva.sv]
// Checker for the fractional shifter, bound to its ports.
// Assumes the single clock domain clk_i with async reset_i.
`timescale 1ns/1ns
`default_nettype none
module fas_shifter_sva (
  input wire logic             clk_i,
  input wire logic             reset_i,
  input wire logic             valid_i,
  input wire fas_pkg::fas_op_e op_i,
  input wire logic [31:0]      shift_operand_i,
  input wire logic [15:0]      count_i,
  input wire logic             to_accum_i,
  input wire logic             clamp_enable_bit_i,
  input wire logic             round_twos_i,
  input wire logic [31:0]      result_o,
  input wire logic             valid_o,
  input wire logic             clamped_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic [4:0] low_count;
  assign low_count = count_i[4:0];
  sequence s_nc_l16;
    valid_i && op_i == fas_pkg::OP_BIDIR_LEFT_NOCLAMP_16 && !to_accum_i;
  endsequence
  sequence s_nc_r16;
    valid_i && op_i == fas_pkg::OP_BIDIR_RIGHT_NOCLAMP_16 && !to_accum_i;
  endsequence
  sequence s_pos_far;
    !count_i[15] && low_count > 5'd15;
  endsequence
  sequence s_neg_far;
    count_i[15] && low_count < 5'd17;
  endsequence
  sequence s_sign_fill;
    result_o == {32{$past(shift_operand_i[15])}};
  endsequence
  latency_one_a: assert property (valid_i |=> valid_o)
    else $error("result not delivered one cycle after request");
  idle_hold_a: assert property (!valid_i |=> !valid_o && $stable(result_o))
    else $error("result changed without a request");
  left_far_zero_a: assert property (s_nc_l16 ##0 s_pos_far |=> result_o == 32'h0000_0000)
    else $error("far left shift not zero");
  left_neg_fill_a: assert property (s_nc_l16 ##0 s_neg_far |=> s_sign_fill)
    else $error("far right shift not sign filled");
  right_pos_fill_a: assert property (s_nc_r16 ##0 s_pos_far |=> s_sign_fill)
    else $error("far right shift not sign filled");
  right_neg_zero_a: assert property (s_nc_r16 ##0 s_neg_far |=> result_o == 32'h0000_0000)
    else $error("far left shift not zero");
  accum_low_clear_a: assert property (valid_i && to_accum_i &&
    op_i < fas_pkg::OP_BIDIR_LEFT_CLAMP_32 |=> result_o[15:0] == 16'h0000)
    else $error("low accumulator portion not cleared");
  noclamp_never_a: assert property (valid_i && (op_i inside {
    fas_pkg::OP_BIDIR_LEFT_NOCLAMP_16, fas_pkg::OP_BIDIR_RIGHT_NOCLAMP_16,
    fas_pkg::OP_BIDIR_LEFT_NOCLAMP_32, fas_pkg::OP_BIDIR_RIGHT_NOCLAMP_32}) |=> !clamped_o)
    else $error("non-clamping shift reported a clamp");
  clamp_value_a: assert property (valid_o && clamped_o |-> result_o inside {
    32'h0000_7fff, 32'hffff_8000, 32'h7fff_0000, 32'h8000_0000, 32'h7fff_ffff})
    else $error("clamped result is not a limit value");
endmodule
bind fas_shifter fas_shifter_sva u_fas_shifter_sva (.clk_i(clk_i), .reset_i(reset_i),
  .valid_i(valid_i), .op_i(op_i), .shift_operand_i(shift_operand_i), .count_i(count_i),
  .to_accum_i(to_accum_i), .clamp_enable_bit_i(clamp_enable_bit_i),
  .round_twos_i(round_twos_i), .result_o(result_o), .valid_o(valid_o), .clamped_o(clamped_o));
`default_nettype wire

// [fractional_arith_shifter_tb.sv]
// Self-checking bench for the fractional shifter with a reference model.
// Assumes the decode model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module fractional_arith_shifter_tb;
  logic             clk_i;
  logic             reset_i;
  logic             valid_i;
  fas_pkg::fas_op_e op_i;
  logic [31:0]      shift_operand_i;
  logic [15:0]      count_i;
  logic             to_accum_i;
  logic             clamp_enable_bit_i;
  logic             round_twos_i;
  logic [31:0]      result_o;
  logic             valid_o;
  logic             clamped_o;
  int               errors;
  int               n_compared;
  logic [32:0]      expq[$];
  logic [15:0]      c;
  int               ks[4] = '{1, 5, 7, 11};
  logic [15:0]      cnts[8] = '{16'h000f, 16'h0010, 16'h7ff1, 16'h001f,
                                16'hfff1, 16'hfff0, 16'h8011, 16'hffef};
  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;
  fas_shifter u_fas_shifter (.clk_i(clk_i), .reset_i(reset_i), .valid_i(valid_i),
    .op_i(op_i), .shift_operand_i(shift_operand_i), .count_i(count_i),
    .to_accum_i(to_accum_i), .clamp_enable_bit_i(clamp_enable_bit_i),
    .round_twos_i(round_twos_i), .result_o(result_o), .valid_o(valid_o), .clamped_o(clamped_o));
  fas_decode_model u_fas_decode_model (.clk_i(clk_i), .valid_o(valid_i), .op_o(op_i),
    .operand_o(shift_operand_i), .count_o(count_i), .to_accum_o(to_accum_i),
    .clamp_en_o(clamp_enable_bit_i), .twos_o(round_twos_i));
  function automatic logic [32:0] model(fas_pkg::fas_op_e op, logic [31:0] a,
                                        logic [15:0] cn, logic acc, logic sat, logic tw);
    int w, k, amt;
    logic nc, left, clp;
    longint v, r, half, lim;
    logic [31:0] o;
    k = int'(op) % 6;
    w = (int'(op) >= 6) ? 32 : 16;
    v = (w == 32) ? longint'($signed(a)) : longint'($signed(a[15:0]));
    lim = 64'sd1 <<< (w - 1);
    nc = (k == 1 || k == 5);
    if (nc) begin
      left = (!cn[15] && cn[4:0] != 0) != (k >= 3);
      amt = cn[15] ? 32 - int'(cn[4:0]) : int'(cn[4:0]);
    end else begin
      amt = ($signed(cn) < 0) ? -int'($signed(cn)) : int'($signed(cn));
      amt = (amt > 63) ? 63 : amt;
      left = (k == 2) || (($signed(cn) > 0) != (k >= 3));
    end
    clp = 1'b0;
    if (left) begin
      r = (amt >= w) ? 0 : v <<< amt;
      clp = !nc && sat && ((amt >= w) ? v != 0 : (r >= lim || r < -lim));
      if (clp) r = (v < 0) ? -lim : lim - 1;
    end else begin
      r = (amt >= w) ? ((v < 0) ? -1 : 0) : v >>> amt;
      if (k == 4 && amt > 0 && amt < w) begin
        half = 64'sd1 <<< (amt - 1);
        if ((v & (2 * half - 1)) > half || ((v & (2 * half - 1)) == half && (tw || r[0]))) r++;
      end
    end
    o = (w == 32) ? r[31:0] : {{16{r[15]}}, r[15:0]};
    if (acc && w == 16) o = {r[15:0], 16'h0000};
    else if (acc && (k == 0 || k == 3)) o[15:0] = 16'h0000;
    return {clp, o};
  endfunction
  task automatic check(string name, logic [32:0] exp_v, logic [32:0] got);
    n_compared++;
    if (got !== exp_v) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp_v, got);
    end
  endtask
  task automatic req(fas_pkg::fas_op_e op, logic [31:0] a, logic [15:0] cn, logic acc);
    expq.push_back(model(op, a, cn, acc, clamp_enable_bit_i, round_twos_i));
    u_fas_decode_model.issue(op, a, cn, acc);
  endtask
  task automatic end_test(string name);
    u_fas_decode_model.idle();
    repeat (2) @(posedge clk_i);
    check("queue", 33'h0, 33'(expq.size()));
    $display("test %s done", name);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(negedge clk_i) begin
    if (!reset_i && valid_o !== 1'b0) begin
      check("result", (expq.size() > 0) ? expq.pop_front() : 33'bx, {clamped_o, result_o});
    end
  end
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
  initial begin
    errors = 0;
    n_compared = 0;
    reset_i = 1'b1;
    void'($urandom(77700));
    repeat (6) @(posedge clk_i);
    #1 reset_i = 1'b0;
    u_fas_decode_model.set_mode(1'b1, 1'b1);
    req(fas_pkg::OP_BIDIR_LEFT_CLAMP_16, 32'h0000_1234, 16'h0001, 1'b0);
    req(fas_pkg::OP_BIDIR_LEFT_CLAMP_16, 32'h0000_4000, 16'h0001, 1'b0);
    req(fas_pkg::OP_LEFT_ONLY_CLAMP_16, 32'h0000_1234, 16'h0003, 1'b1);
    req(fas_pkg::OP_LEFT_ONLY_CLAMP_32, 32'hc000_0000, 16'hfffe, 1'b0);
    req(fas_pkg::OP_BIDIR_RIGHT_CLAMP_32, 32'h1234_5678, 16'hffff, 1'b1);
    req(fas_pkg::OP_BIDIR_RIGHT_ROUND_32, 32'h4111_1111, 16'h0001, 1'b0);
    req(fas_pkg::OP_BIDIR_RIGHT_ROUND_16, 32'h0000_7fff, 16'hffff, 1'b0);
    u_fas_decode_model.set_mode(1'b0, 1'b0);
    req(fas_pkg::OP_LEFT_ONLY_CLAMP_16, 32'h0000_1234, 16'h0003, 1'b0);
    req(fas_pkg::OP_BIDIR_RIGHT_ROUND_16, 32'h0000_0005, 16'h0001, 1'b0);
    req(fas_pkg::OP_BIDIR_LEFT_NOCLAMP_16, 32'h0000_8001, 16'h0020, 1'b0);
    end_test("examples");
    foreach (ks[i]) foreach (cnts[j]) for (int s = 0; s < 4; s++)
      req(fas_pkg::fas_op_e'(4'(ks[i])), s[0] ? 32'h8765_c321 : 32'h1234_5678, cnts[j],
          s[1]);
    end_test("thresholds");
    repeat (400) begin
      c = 16'($urandom);
      if ($urandom_range(1) == 1) c = 16'($urandom_range(80)) - 16'd40;
      if ($urandom_range(40) == 0)
        u_fas_decode_model.set_mode(1'($urandom_range(1)), 1'($urandom_range(1)));
      if ($urandom_range(5) == 0) u_fas_decode_model.idle();
      req(fas_pkg::fas_op_e'(4'($urandom_range(11))), $urandom, c,
          1'($urandom_range(1)));
    end
    end_test("random");
    u_fas_decode_model.issue(fas_pkg::OP_LEFT_ONLY_CLAMP_32, 32'h7fff_ffff, 16'h0004, 1'b1);
    reset_i = 1'b1;
    u_fas_decode_model.idle();
    #1 check("reset", 33'h0, {valid_o | clamped_o, result_o});
    repeat (6) @(posedge clk_i);
    #1 reset_i = 1'b0;
    req(fas_pkg::OP_BIDIR_LEFT_NOCLAMP_32, 32'h1234_5678, 16'h0001, 1'b1);
    end_test("reset");
    tally_and_finish();
  end
endmodule
`default_nettype wire
